// ===== meas_pkg.sv
`default_nettype none
package meas_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [5:0]  ADDR_SETUP    = 6'h01;
  localparam logic [5:0]  ADDR_SCALE    = 6'h02;
  localparam logic [5:0]  ADDR_DRIFT    = 6'h03;
  localparam logic [5:0]  ADDR_SHUNT    = 6'h04;
  localparam logic [15:0] SETUP_RESET   = 16'hFB68;
  localparam logic [14:0] SCALE_RESET   = 15'h1000;
  localparam logic [13:0] DRIFT_RESET   = 14'h0000;
  localparam logic [19:0] SHUNT_RESET   = 20'h00000;
  // ----------------------------------------
  // setup field positions and other register field widths
  // ----------------------------------------
  localparam int MODE_LSB    = 12;
  localparam int BUS_CT_LSB  = 9;
  localparam int SHUNT_CT_LSB = 6;
  localparam int TEMP_CT_LSB = 3;
  localparam int AVG_LSB     = 0;
  localparam int SCALE_W     = 15;
  localparam int DRIFT_W     = 14;
  localparam int SHUNT_W     = 20;
  localparam int SHUNT_LSB   = 4;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CONV_TIME_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  typedef enum logic [1:0] {S_IDLE, S_BUS, S_SHUNT, S_TEMP} engine_state_t;
endpackage
`default_nettype wire

// ===== meas_engine.sv
`default_nettype none
module meas_engine #(
  parameter int unsigned CYCLES_PER_US = meas_pkg::CLK_MHZ
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        softReset,
  input  wire logic [5:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [15:0] regWriteData,
  input  wire logic        regRead,
  output logic      [23:0] regReadData,
  input  wire logic [19:0] shuntSample,
  input  wire logic        shunt_range_select,
  input  wire logic        drift_correction_enable,
  output logic             busConvActive,
  output logic             shuntConvActive,
  output logic             tempConvActive,
  output logic             resultUpdate,
  output logic             shuntRange,
  output logic      [14:0] calScale,
  output logic      [13:0] driftApplied
);
  import meas_pkg::*;

  logic [15:0]   measurement_setup;
  logic [14:0]   shunt_drift_scale;
  logic [13:0]   shunt_drift_value;
  logic [19:0]   shunt_voltage_result;
  logic [29:0]   accum;
  logic [31:0]   convCount;
  logic [9:0]    setCount;
  logic          trigPending;
  engine_state_t state;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] convCycles(input logic [2:0] code);
    convCycles = 32'(CONV_TIME_US[code] * CYCLES_PER_US - 1);
  endfunction

  function automatic logic [3:0] avgShift(input logic [2:0] code);
    case (code)
      3'h0: avgShift = 4'h0;
      3'h1: avgShift = 4'h2;
      3'h2: avgShift = 4'h4;
      3'h3: avgShift = 4'h6;
      default: avgShift = 4'(code) + 4'h3;
    endcase
  endfunction

  // first enabled channel after the given one, in bus, shunt, temperature order
  function automatic engine_state_t nextChannel(input engine_state_t from, input logic [2:0] chans);
    nextChannel = S_IDLE;
    if (from == S_IDLE && chans[0]) nextChannel = S_BUS;
    else if ((from == S_IDLE || from == S_BUS) && chans[1]) nextChannel = S_SHUNT;
    else if (from != S_TEMP && chans[2]) nextChannel = S_TEMP;
  endfunction

  logic [3:0]    mode;
  logic [2:0]    chans;
  logic          shutdown;
  logic          continuous;
  logic [9:0]    avgLast;
  logic          setupWrite;
  logic          convEnd;
  logic          setEnd;
  logic          runEnd;
  logic          startRun;
  logic [29:0]   accumSum;
  engine_state_t next_chan;
  engine_state_t first_chan;
  logic [31:0]   next_count;

  assign mode       = measurement_setup[MODE_LSB +: 4];
  assign chans      = mode[2:0];
  assign shutdown   = (chans == 3'h0);
  assign continuous = mode[3];
  assign avgLast    = 10'((32'h1 << avgShift(measurement_setup[AVG_LSB +: 3])) - 1);
  assign setupWrite = regWrite && regAddr == ADDR_SETUP;
  assign convEnd    = (state != S_IDLE) && convCount == 32'h0;
  assign next_chan  = nextChannel(state, chans);
  assign first_chan = nextChannel(S_IDLE, chans);
  assign setEnd     = convEnd && next_chan == S_IDLE;
  assign runEnd     = setEnd && setCount == avgLast;
  assign startRun   = !shutdown && (continuous || trigPending);
  assign accumSum   = accum + ((state == S_SHUNT && convEnd) ? 30'(signed'(shuntSample)) : 30'h0);

  // count to load for the channel about to convert
  always_comb begin
    engine_state_t target;
    target = (state == S_IDLE || setEnd) ? first_chan : next_chan;
    case (target)
      S_BUS:   next_count = convCycles(measurement_setup[BUS_CT_LSB +: 3]);
      S_SHUNT: next_count = convCycles(measurement_setup[SHUNT_CT_LSB +: 3]);
      S_TEMP:  next_count = convCycles(measurement_setup[TEMP_CT_LSB +: 3]);
      default: next_count = 32'h0;
    endcase
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      measurement_setup <= SETUP_RESET;
      shunt_drift_scale <= SCALE_RESET;
      shunt_drift_value <= DRIFT_RESET;
    end else if (softReset) begin
      measurement_setup <= SETUP_RESET;
      shunt_drift_scale <= SCALE_RESET;
      shunt_drift_value <= DRIFT_RESET;
    end else if (regWrite) begin
      // result register and reserved bits keep their contents
      if (regAddr == ADDR_SETUP) begin
        measurement_setup <= regWriteData;
      end else if (regAddr == ADDR_SCALE) begin
        shunt_drift_scale <= regWriteData[SCALE_W-1:0];
      end else if (regAddr == ADDR_DRIFT) begin
        shunt_drift_value <= regWriteData[DRIFT_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state       <= S_IDLE;
      convCount   <= 32'h0;
      setCount    <= 10'h0;
      trigPending <= 1'b0;
    end else if (softReset || setupWrite) begin
      // a new setup aborts the run in flight; a triggered code arms one run
      state       <= S_IDLE;
      convCount   <= 32'h0;
      setCount    <= 10'h0;
      trigPending <= setupWrite && !regWriteData[MODE_LSB + 3] && regWriteData[MODE_LSB +: 3] != 3'h0;
    end else if (shutdown) begin
      state       <= S_IDLE;
      trigPending <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (startRun) begin
            state       <= first_chan;
            convCount   <= next_count;
            trigPending <= 1'b0;
          end
        end
        default: begin
          if (!convEnd) begin
            convCount <= convCount - 32'h1;
          end else if (!setEnd) begin
            state     <= next_chan;
            convCount <= next_count;
          end else if (!runEnd) begin
            setCount  <= setCount + 10'h1;
            state     <= first_chan;
            convCount <= next_count;
          end else begin
            setCount  <= 10'h0;
            state     <= continuous ? first_chan : S_IDLE;
            convCount <= next_count;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // averaging and shunt result
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      accum                <= 30'h0;
      shunt_voltage_result <= SHUNT_RESET;
      resultUpdate         <= 1'b0;
    end else if (softReset || setupWrite) begin
      accum                <= 30'h0;
      shunt_voltage_result <= softReset ? SHUNT_RESET : shunt_voltage_result;
      resultUpdate         <= 1'b0;
    end else if (runEnd && !shutdown) begin
      // only the finished average reaches the result register
      accum        <= 30'h0;
      resultUpdate <= 1'b1;
      if (chans[1]) begin
        shunt_voltage_result <= 20'(signed'(accumSum) >>> avgShift(measurement_setup[AVG_LSB +: 3]));
      end
    end else begin
      accum        <= accumSum;
      resultUpdate <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs and read port
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busConvActive   <= 1'b0;
      shuntConvActive <= 1'b0;
      tempConvActive  <= 1'b0;
      shuntRange      <= 1'b0;
      calScale        <= SCALE_RESET;
      driftApplied    <= DRIFT_RESET;
    end else begin
      busConvActive   <= state == S_BUS;
      shuntConvActive <= state == S_SHUNT;
      tempConvActive  <= state == S_TEMP;
      shuntRange      <= shunt_range_select;
      calScale        <= shunt_drift_scale;
      driftApplied    <= drift_correction_enable ? shunt_drift_value : DRIFT_RESET;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regReadData <= 24'h000000;
    end else if (regRead) begin
      if (regAddr == ADDR_SETUP) begin
        regReadData <= {8'h00, measurement_setup};
      end else if (regAddr == ADDR_SCALE) begin
        regReadData <= {9'h000, shunt_drift_scale};
      end else if (regAddr == ADDR_DRIFT) begin
        regReadData <= {10'h000, shunt_drift_value};
      end else if (regAddr == ADDR_SHUNT) begin
        regReadData <= {shunt_voltage_result, 4'h0};
      end else begin
        regReadData <= 24'h000000;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence quietShutdown;
    shutdown && !softReset && !setupWrite;
  endsequence
  sequence finalSet;
    runEnd && !shutdown && !softReset && !setupWrite;
  endsequence

  a_shutdown_stops: assert property (quietShutdown |=> state == S_IDLE ##1 !busConvActive && !shuntConvActive && !tempConvActive)
    else $error("conversion running in shutdown");
  a_single_shot_stop: assert property (finalSet ##0 !continuous |=> state == S_IDLE ##1 !resultUpdate)
    else $error("triggered run did not stop");
  a_continuous_loop: assert property (finalSet ##0 continuous |=> state == $past(first_chan))
    else $error("continuous run did not restart");
  a_bus_time: assert property ($rose(state == S_BUS) |-> convCount == convCycles(measurement_setup[11:9]))
    else $error("bus conversion length wrong");
  a_shunt_time: assert property ($rose(state == S_SHUNT) |-> convCount == convCycles(measurement_setup[8:6]))
    else $error("shunt conversion length wrong");
  a_temp_time: assert property ($rose(state == S_TEMP) |-> convCount == convCycles(measurement_setup[5:3]))
    else $error("temperature conversion length wrong");
  a_avg_update: assert property (resultUpdate |-> $past(setCount) == $past(avgLast))
    else $error("result updated before averaging finished");
  a_result_hold: assert property (!softReset && !(runEnd && !shutdown && !setupWrite) |=> $stable(shunt_voltage_result))
    else $error("shunt result changed mid run");
  a_scale_reserved: assert property (regRead && regAddr == ADDR_SCALE |=> regReadData[23:15] == 9'h000)
    else $error("scale reserved bits not zero");
  a_drift_reserved: assert property (regRead && regAddr == ADDR_DRIFT |=> regReadData[23:14] == 10'h000)
    else $error("drift reserved bits not zero");
  a_shunt_layout: assert property (regRead && regAddr == ADDR_SHUNT |=> regReadData == {$past(shunt_voltage_result), 4'h0})
    else $error("shunt result layout wrong");
  a_drift_gate: assert property (!drift_correction_enable |=> driftApplied == 14'h0000)
    else $error("drift applied while disabled");
endmodule
`default_nettype wire

// ===== measurement_config_and_shunt_result_bench.sv
`default_nettype none
module measurement_config_and_shunt_result_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import meas_pkg::*;
  logic        clk_sys;
  logic        arst_n;
  logic        softReset;
  logic [5:0]  regAddr;
  logic        regWrite;
  logic [15:0] regWriteData;
  logic        regRead;
  logic [23:0] regReadData;
  logic [19:0] shuntSample;
  logic        shunt_range_select;
  logic        drift_correction_enable;
  logic        busConvActive;
  logic        shuntConvActive;
  logic        tempConvActive;
  logic        resultUpdate;
  logic        shuntRange;
  logic [14:0] calScale;
  logic [13:0] driftApplied;
  int          errors;
  int          comparisons;

  // one cycle per microsecond keeps every conversion between 50 and 4120 cycles
  meas_engine #(.CYCLES_PER_US(1)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .softReset(softReset), .regAddr(regAddr),
    .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
    .regReadData(regReadData), .shuntSample(shuntSample),
    .shunt_range_select(shunt_range_select), .drift_correction_enable(drift_correction_enable),
    .busConvActive(busConvActive), .shuntConvActive(shuntConvActive),
    .tempConvActive(tempConvActive), .resultUpdate(resultUpdate), .shuntRange(shuntRange),
    .calScale(calScale), .driftApplied(driftApplied));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk24({23'h000000, got}, {23'h000000, exp});
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    chk24(regReadData, exp);
  endtask

  // bounded wait for the next update pulse; n counts the cycles waited
  task automatic wait_update(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 5000) begin
        errors++;
        complete_run();
      end
    end while (resultUpdate !== 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_registers;
    rd(ADDR_SETUP, 24'h00FB68);
    rd(ADDR_SCALE, 24'h001000);
    rd(ADDR_DRIFT, 24'h000000);
    rd(ADDR_SHUNT, 24'h000000);
    rd(6'h3F, 24'h000000);
    wr(ADDR_SCALE, 16'hFFFF);
    wr(ADDR_DRIFT, 16'hFFFF);
    wr(ADDR_SHUNT, 16'hFFFF);
    rd(ADDR_SCALE, 24'h007FFF);
    rd(ADDR_DRIFT, 24'h003FFF);
    rd(ADDR_SHUNT, 24'h000000);
    chk24({9'h000, calScale}, 24'h007FFF);
    chk24({10'h000, driftApplied}, 24'h000000);
    drift_correction_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk24({10'h000, driftApplied}, 24'h003FFF);
    shunt_range_select = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk1(shuntRange, 1'b1);
    wr(ADDR_SETUP, 16'h1234);
    rd(ADDR_SETUP, 24'h001234);
    softReset = 1'b1;
    @(negedge clk_sys);
    softReset = 1'b0;
    rd(ADDR_SETUP, 24'h00FB68);
    rd(ADDR_SCALE, 24'h001000);
  endtask

  // every mode code, all conversion times at the shortest setting
  task automatic t_modes;
    logic [2:0] seen;
    int         pulses;
    logic       ok;
    shuntSample = 20'h12345;
    for (int m = 0; m < 16; m++) begin
      wr(ADDR_SETUP, 16'h0000);
      repeat (2) @(negedge clk_sys);
      wr(ADDR_SETUP, {m[3:0], 12'h000});
      seen = 3'b000;
      pulses = 0;
      repeat (400) begin
        @(negedge clk_sys);
        seen |= {tempConvActive, shuntConvActive, busConvActive};
        pulses += int'(resultUpdate);
      end
      // a single-shot set takes at most 150 cycles, so continuous runs show several
      ok = (m[2:0] == 3'h0) ? (pulses == 0) : (m[3] ? (pulses > 1) : (pulses == 1));
      chk24({21'h000000, seen}, {21'h000000, m[2:0]});
      chk1(ok, 1'b1);
    end
    rd(ADDR_SHUNT, 24'h123450);
  endtask

  // spacing of updates follows conversion time times averaging count
  task automatic t_gap(input logic [15:0] setup, input int expc);
    int n;
    wr(ADDR_SETUP, setup);
    wait_update(n);
    wait_update(n);
    chk1(n >= expc && n <= expc + 16, 1'b1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    errors = 0;
    comparisons = 0;
    arst_n = 1'b0;
    softReset = 1'b0;
    regAddr = 6'h00;
    regWrite = 1'b0;
    regWriteData = 16'h0000;
    regRead = 1'b0;
    shuntSample = 20'h00000;
    shunt_range_select = 1'b0;
    drift_correction_enable = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    t_registers();
    t_modes();
    t_gap(16'h9400, 150);
    t_gap(16'hC018, 280);
    shuntSample = 20'hFFF80;
    t_gap(16'hA041, 336);
    rd(ADDR_SHUNT, 24'hFFF800);
    t_gap(16'hA002, 800);
    t_gap(16'hA003, 3200);
    t_gap(16'h9E00, 4120);
    complete_run();
  end
endmodule
`default_nettype wire
